// ---- verilog/opmode_pkg.sv ----
// shared constants and carriers of the operating-mode controller
// assumes a single 125 MHz clock and an AHB-Lite register slave
package opmode_pkg;

	// ****************************************
	// register offsets
	// ****************************************
	localparam logic [7:0] OFS_CTRL    = 8'h00;
	localparam logic [7:0] OFS_SEG     = 8'h04;
	localparam logic [7:0] OFS_PREFIX  = 8'h08;
	localparam logic [7:0] OFS_STATUS  = 8'h0C;
	localparam logic [7:0] OFS_SAVED   = 8'h10;
	localparam logic [7:0] OFS_SMRET   = 8'h14;

	// ****************************************
	// field positions, reset values, register counts and widths, and bus codes
	// ****************************************
	localparam int         CTRL_PROT_BIT  = 0;
	localparam int         CTRL_EXT_BIT   = 1;
	localparam int         CTRL_PAE_BIT   = 2;
	localparam int         SEG_LONG_BIT   = 0;
	localparam int         SEG_D32_BIT    = 1;
	localparam int         SEG_VR86_BIT   = 2;
	localparam int         PFX_REGEXT_BIT = 0;
	localparam int         PFX_WIDE_BIT   = 1;
	localparam int         PFX_OPSZ_BIT   = 2;
	localparam int         PFX_ADSZ_BIT   = 3;
	localparam int         SMRET_BIT      = 0;
	localparam logic [2:0] CTRL_RST       = 3'h0;
	localparam logic [2:0] SEG_RST        = 3'h0;
	localparam logic [3:0] PFX_RST        = 4'h0;
	localparam logic [4:0] REGS_NARROW    = 5'h08;
	localparam logic [4:0] REGS_WIDE      = 5'h10;
	localparam logic [6:0] GPR_W32        = 7'h20;
	localparam logic [6:0] GPR_W64        = 7'h40;
	localparam logic [1:0] HTRANS_NONSEQ  = 2'h2;
	localparam logic       HRESP_OKAY     = 1'h0;
	localparam logic [2:0] HSIZE_WORD     = 3'h2;

	// ****************************************
	// types
	// ****************************************
	typedef enum logic [1:0] {
		MODE_REAL    = 2'b00,
		MODE_PROT    = 2'b01,
		MODE_SYSMGMT = 2'b10
	} mode_t;

	typedef enum logic [1:0] {
		SUB_LEGACY = 2'b00,
		SUB_COMPAT = 2'b01,
		SUB_64     = 2'b10
	} submode_t;

	typedef enum logic [1:0] {
		SZ_16 = 2'b00,
		SZ_32 = 2'b01,
		SZ_64 = 2'b10
	} size_t;

	// execution environment, also the status word
	typedef struct packed {
		mode_t      mode;
		submode_t   submode;
		size_t      addr_size;
		size_t      oper_size;
		logic [4:0] gpr_count;
		logic [4:0] simd_count;
		logic [6:0] gpr_width;
		logic       lin_4g;
		logic       pae_ok;
		logic       vr86_act;
		logic       task_sw_ok;
		logic       smram_sel;
		logic       view8_ok;
		logic       view16_ok;
	} exec_env_t;

	// context held across a system-management visit
	typedef struct packed {
		mode_t      mode;
		logic [2:0] ctrl;
		logic [2:0] seg;
	} saved_ctx_t;

endpackage

// ---- verilog/opmode_ctrl.sv ----
// operating-mode controller of the processor core
// assumes AHB-Lite with this block as the only slave, single clock REF_CLK
//
// Overview of operation
// R1 - three basic modes: protected, real, sysmgmt
// R2 - any reset starts in real-address mode
// R3 - pin or controller message enters sysmgmt mode
// R4 - entry saves context, selects separate address space
// R5 - return restores saved context exactly
// R6 - virtual-real is per-task protected attribute
// R7 - extended mode: compatibility and 64-bit sub-modes
// R8 - compatibility chosen per code segment
// R9 - compatibility limits linear space to 4 GByte
// R10 - compatibility: only 16/32-bit sizes
// R11 - compatibility may reach high memory via extension
// R12 - compatibility: no virtual-real, no task switch
// R13 - 64-bit sub-mode chosen per code segment
// R14 - 64-bit: 16 general and SIMD registers
// R15 - 64-bit: general registers 64 bits wide
// R16 - 64-bit: address 64, operand 32 default
// R17 - prefix pair overrides operand size, one instruction
// R18 - register-extension prefix: added registers, 64-bit operands
// R19 - low 8/16-bit views of general registers
// R20 - mode changes only on reset, sysmgmt, software
`timescale 1ns/1ns
module opmode_ctrl (
	input  wire logic                   REF_CLK,
	input  wire logic                   SYS_RST,
	input  wire logic                   HSEL,
	input  wire logic [31:0]            HADDR,
	input  wire logic [1:0]             HTRANS,
	input  wire logic                   HWRITE,
	input  wire logic [2:0]             HSIZE,
	input  wire logic [31:0]            HWDATA,
	input  wire logic                   HREADY,
	output logic                        HREADYOUT,
	output logic [31:0]                 HRDATA,
	output logic                        HRESP,
	input  wire logic                   SYS_MGMT_INTERRUPT_PIN_N,
	input  wire logic                   PIC_SYS_MGMT_MSG,
	input  wire logic                   INSN_RETIRE,
	output opmode_pkg::exec_env_t       EXEC_ENV
);

	// ****************************************
	// bus slave
	// ****************************************
	logic       dph_wr_q;
	logic       rd_wait_q;
	logic [7:0] dph_addr_q;
	logic       dph_map_q;
	logic [31:0] hrdata_q;
	logic        addr_take;
	logic        wr_now;
	logic        addr_mapped;

	// only aligned whole-word transfers in the low 256 bytes reach a register
	assign addr_take   = HSEL & (HTRANS == opmode_pkg::HTRANS_NONSEQ) & HREADY;
	assign addr_mapped = (HADDR[31:8] == 24'h000000) & (HADDR[1:0] == 2'h0) & (HSIZE == opmode_pkg::HSIZE_WORD);
	assign wr_now      = dph_wr_q & HREADY;
	assign HREADYOUT   = ~rd_wait_q;
	assign HRDATA      = hrdata_q;
	assign HRESP       = opmode_pkg::HRESP_OKAY;

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			dph_wr_q   <= 1'b0;
			rd_wait_q  <= 1'b0;
			dph_addr_q <= 8'h00;
			dph_map_q  <= 1'b0;
		end else begin
			if (addr_take) begin
				dph_wr_q   <= HWRITE;
				rd_wait_q  <= ~HWRITE;
				dph_addr_q <= HADDR[7:0];
				dph_map_q  <= addr_mapped;
			end else begin
				if (HREADY) begin
					dph_wr_q <= 1'b0;
				end
				rd_wait_q <= 1'b0;
			end
		end
	end

	// ****************************************
	// software-visible control state
	// ****************************************
	logic [2:0]             ctrl_q;
	logic [2:0]             seg_q;
	logic [3:0]             pfx_q;
	opmode_pkg::mode_t      mode_q;
	opmode_pkg::saved_ctx_t saved_q;
	logic                   wr_ctrl;
	logic                   wr_seg;
	logic                   wr_pfx;
	logic                   wr_ret;
	logic                   in_sysmgmt;
	logic                   do_enter;
	logic                   do_return;

	// ****************************************
	// register write decode
	// ****************************************
	always_comb begin
		wr_ctrl = 1'b0;
		wr_seg  = 1'b0;
		wr_pfx  = 1'b0;
		wr_ret  = 1'b0;
		if (!(wr_now && dph_map_q)) begin
			wr_ctrl = 1'b0;
		end else if (dph_addr_q == opmode_pkg::OFS_CTRL) begin
			wr_ctrl = 1'b1;
		end else if (dph_addr_q == opmode_pkg::OFS_SEG) begin
			wr_seg = 1'b1;
		end else if (dph_addr_q == opmode_pkg::OFS_PREFIX) begin
			wr_pfx = 1'b1;
		end else if (dph_addr_q == opmode_pkg::OFS_SMRET) begin
			wr_ret = HWDATA[opmode_pkg::SMRET_BIT];
		end
	end

	// ****************************************
	// sysmgmt entry and return
	// ****************************************
	assign in_sysmgmt = (mode_q == opmode_pkg::MODE_SYSMGMT);
	assign do_return  = wr_ret & in_sysmgmt;

	// ****************************************
	// sysmgmt request: pin synchroniser and pending flag
	// ****************************************
	logic pin_s1_q;
	logic pin_s2_q;
	logic pin_s3_q;
	logic pin_fall;
	logic pend_q;
	logic req_now;

	// reset to the pin's pulled-up idle level so no false edge follows reset
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pin_s1_q <= 1'b1;
			pin_s2_q <= 1'b1;
			pin_s3_q <= 1'b1;
		end else begin
			pin_s1_q <= SYS_MGMT_INTERRUPT_PIN_N;
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
		end
	end

	assign pin_fall = pin_s3_q & ~pin_s2_q;
	assign req_now  = pin_fall | PIC_SYS_MGMT_MSG;                       // [R3]
	assign do_enter = (pend_q | req_now) & ~in_sysmgmt & ~do_return;

	// ****************************************
	// pending request
	// ****************************************
	// a request arriving while already inside stays pending until after return
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pend_q <= 1'b0;
		end else if (req_now && in_sysmgmt) begin
			pend_q <= 1'b1;                                               // [R3]
		end else if (do_enter) begin
			pend_q <= 1'b0;
		end
	end

	// ****************************************
	// mode state
	// ****************************************
	// return beats entry, and both beat software writes
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			mode_q <= opmode_pkg::MODE_REAL;                              // [R2]
		end else if (do_enter) begin
			mode_q <= opmode_pkg::MODE_SYSMGMT;                           // [R1] [R4]
		end else if (do_return) begin
			mode_q <= saved_q.mode;                                       // [R5]
		end else if (wr_ctrl && !in_sysmgmt) begin
			if (HWDATA[opmode_pkg::CTRL_PROT_BIT]) begin                  // [R20]
				mode_q <= opmode_pkg::MODE_PROT;
			end else begin
				mode_q <= opmode_pkg::MODE_REAL;
			end
		end
	end

	// ****************************************
	// saved context
	// ****************************************
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			saved_q <= '{opmode_pkg::MODE_REAL, opmode_pkg::CTRL_RST, opmode_pkg::SEG_RST};
		end else if (do_enter) begin
			saved_q <= '{mode_q, ctrl_q, seg_q};                          // [R4]
		end
	end

	// ****************************************
	// control and segment registers
	// ****************************************
	// sysmgmt code runs in a clean real-like setting
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			ctrl_q <= opmode_pkg::CTRL_RST;
			seg_q  <= opmode_pkg::SEG_RST;
		end else if (do_enter) begin
			ctrl_q <= opmode_pkg::CTRL_RST;
			seg_q  <= opmode_pkg::SEG_RST;
		end else if (do_return) begin
			ctrl_q <= saved_q.ctrl;                                       // [R5]
			seg_q  <= saved_q.seg;
		end else begin
			if (wr_ctrl) begin
				ctrl_q <= HWDATA[2:0];
			end
			if (wr_seg) begin
				seg_q <= HWDATA[2:0];                                     // [R8] [R13]
			end
		end
	end

	// ****************************************
	// prefix state
	// ****************************************
	// prefix state lasts one instruction; a new write beats the retire clear
	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			pfx_q <= opmode_pkg::PFX_RST;
		end else if (wr_pfx) begin
			pfx_q <= HWDATA[3:0];
		end else if (INSN_RETIRE || do_enter || do_return) begin
			pfx_q <= opmode_pkg::PFX_RST;                                 // [R17]
		end
	end

	// ****************************************
	// environment decode
	// ****************************************
	opmode_pkg::exec_env_t env_d;
	opmode_pkg::exec_env_t env_q;
	opmode_pkg::submode_t  sub_d;
	opmode_pkg::size_t     addr_d;
	opmode_pkg::size_t     oper_d;
	logic                  is_prot;
	logic                  ext_on;
	logic                  dflt32;
	logic                  regext;
	logic                  wide;
	logic                  opsz;
	logic                  adsz;

	assign is_prot = (mode_q == opmode_pkg::MODE_PROT);
	assign ext_on  = is_prot & ctrl_q[opmode_pkg::CTRL_EXT_BIT];
	assign dflt32  = seg_q[opmode_pkg::SEG_D32_BIT] & (mode_q != opmode_pkg::MODE_REAL);
	assign regext  = pfx_q[opmode_pkg::PFX_REGEXT_BIT];
	assign wide    = pfx_q[opmode_pkg::PFX_WIDE_BIT];
	assign opsz    = pfx_q[opmode_pkg::PFX_OPSZ_BIT];
	assign adsz    = pfx_q[opmode_pkg::PFX_ADSZ_BIT];

	always_comb begin
		if (!ext_on) begin
			sub_d = opmode_pkg::SUB_LEGACY;
		end else if (seg_q[opmode_pkg::SEG_LONG_BIT]) begin
			sub_d = opmode_pkg::SUB_64;                                   // [R7] [R13]
		end else begin
			sub_d = opmode_pkg::SUB_COMPAT;                               // [R7] [R8]
		end
	end

	// ****************************************
	// address and operand size
	// ****************************************
	// regext and wide mean nothing outside the 64-bit sub-mode
	always_comb begin
		if (sub_d == opmode_pkg::SUB_64) begin
			if (adsz) begin
				addr_d = opmode_pkg::SZ_32;
			end else begin
				addr_d = opmode_pkg::SZ_64;                               // [R16]
			end
			if (regext && wide) begin
				oper_d = opmode_pkg::SZ_64;                               // [R17] [R18]
			end else if (opsz) begin
				oper_d = opmode_pkg::SZ_16;                               // [R17]
			end else begin
				oper_d = opmode_pkg::SZ_32;                               // [R16]
			end
		end else begin
			if (dflt32 ^ adsz) begin
				addr_d = opmode_pkg::SZ_32;                               // [R10]
			end else begin
				addr_d = opmode_pkg::SZ_16;
			end
			if (dflt32 ^ opsz) begin
				oper_d = opmode_pkg::SZ_32;                               // [R10]
			end else begin
				oper_d = opmode_pkg::SZ_16;
			end
		end
	end

	// ****************************************
	// status word
	// ****************************************
	always_comb begin
		env_d            = '0;
		env_d.mode       = mode_q;                                        // [R1]
		env_d.submode    = sub_d;
		env_d.addr_size  = addr_d;
		env_d.oper_size  = oper_d;
		env_d.smram_sel  = in_sysmgmt;                                    // [R4]
		env_d.view8_ok   = 1'b1;                                          // [R19]
		env_d.view16_ok  = 1'b1;                                          // [R19]
		env_d.pae_ok     = is_prot & ctrl_q[opmode_pkg::CTRL_PAE_BIT];    // [R11]
		if (sub_d == opmode_pkg::SUB_64) begin
			env_d.gpr_count  = opmode_pkg::REGS_WIDE;                     // [R14]
			env_d.simd_count = opmode_pkg::REGS_WIDE;                     // [R14]
			env_d.gpr_width  = opmode_pkg::GPR_W64;                       // [R15]
			env_d.lin_4g     = 1'b0;
		end else begin
			env_d.gpr_count  = opmode_pkg::REGS_NARROW;
			env_d.simd_count = opmode_pkg::REGS_NARROW;
			env_d.gpr_width  = opmode_pkg::GPR_W32;
			env_d.lin_4g     = 1'b1;                                      // [R9]
		end
		// virtual-real and hardware task switch only in legacy protected
		env_d.task_sw_ok = is_prot & (sub_d == opmode_pkg::SUB_LEGACY);          // [R12]
		env_d.vr86_act   = env_d.task_sw_ok & seg_q[opmode_pkg::SEG_VR86_BIT];   // [R6] [R12]
	end

	// ****************************************
	// environment register
	// ****************************************

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			env_q      <= '0;
			env_q.mode <= opmode_pkg::MODE_REAL;                          // [R2]
		end else begin
			env_q <= env_d;
		end
	end

	assign EXEC_ENV = env_q;

	// ****************************************
	// read data
	// ****************************************
	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h00000000;
		if (!dph_map_q) begin
			rd_mux = 32'h00000000;
		end else if (dph_addr_q == opmode_pkg::OFS_CTRL) begin
			rd_mux = {29'h0, ctrl_q};
		end else if (dph_addr_q == opmode_pkg::OFS_SEG) begin
			rd_mux = {29'h0, seg_q};
		end else if (dph_addr_q == opmode_pkg::OFS_PREFIX) begin
			rd_mux = {28'h0000000, pfx_q};
		end else if (dph_addr_q == opmode_pkg::OFS_STATUS) begin
			rd_mux = env_q;
		end else if (dph_addr_q == opmode_pkg::OFS_SAVED) begin
			rd_mux = {24'h000000, saved_q};
		end
	end

	always_ff @(posedge REF_CLK) begin
		if (SYS_RST) begin
			hrdata_q <= 32'h00000000;
		end else if (rd_wait_q) begin
			hrdata_q <= rd_mux;
		end
	end

endmodule

// ---- dv/opmode_ctrl_properties.sv ----
// concurrent checks on the operating-mode controller ports
// assumes binding to opmode_ctrl with one clock REF_CLK
`timescale 1ns/1ns
module opmode_ctrl_properties (
	input wire logic                  REF_CLK,
	input wire logic                  SYS_RST,
	input wire logic                  HSEL,
	input wire logic [1:0]            HTRANS,
	input wire logic                  HWRITE,
	input wire logic                  HREADY,
	input wire logic                  HREADYOUT,
	input wire logic                  SYS_MGMT_INTERRUPT_PIN_N,
	input wire logic                  PIC_SYS_MGMT_MSG,
	input wire opmode_pkg::exec_env_t EXEC_ENV
);
	// ****************************************
	// properties
	// ****************************************
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (SYS_RST);
	logic take;
	assign take = HSEL && HTRANS == opmode_pkg::HTRANS_NONSEQ && HREADY;

	a_read_wait: assert property (take && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
		else $error("read wait state wrong");
	a_write_nowait: assert property (take && HWRITE |=> HREADYOUT)
		else $error("write stalled");
	a_reset_real: assert property ($fell(SYS_RST) |-> EXEC_ENV.mode == opmode_pkg::MODE_REAL
		##3 EXEC_ENV.gpr_width == opmode_pkg::GPR_W32) else $error("not real mode after reset");
	a_msg_entry: assert property (PIC_SYS_MGMT_MSG && EXEC_ENV.mode != opmode_pkg::MODE_SYSMGMT
		|-> ##2 EXEC_ENV.mode == opmode_pkg::MODE_SYSMGMT) else $error("message entry missed");
	a_pin_entry: assert property ($fell(SYS_MGMT_INTERRUPT_PIN_N) && EXEC_ENV.mode != opmode_pkg::MODE_SYSMGMT
		|-> ##[2:8] EXEC_ENV.mode == opmode_pkg::MODE_SYSMGMT) else $error("pin entry missed");
	a_entry_space: assert property (EXEC_ENV.smram_sel == (EXEC_ENV.mode == opmode_pkg::MODE_SYSMGMT))
		else $error("address space select wrong");
	a_entry_clear: assert property ($changed(EXEC_ENV.mode) && EXEC_ENV.mode == opmode_pkg::MODE_SYSMGMT
		|-> EXEC_ENV.submode == opmode_pkg::SUB_LEGACY && EXEC_ENV.oper_size == opmode_pkg::SZ_16)
		else $error("entry state not cleared");
	a_sub64_regs: assert property (EXEC_ENV.submode == opmode_pkg::SUB_64 |-> EXEC_ENV.gpr_count ==
		opmode_pkg::REGS_WIDE && EXEC_ENV.simd_count == opmode_pkg::REGS_WIDE && EXEC_ENV.gpr_width == opmode_pkg::GPR_W64)
		else $error("64-bit register set wrong");
	a_compat_lim: assert property (EXEC_ENV.submode == opmode_pkg::SUB_COMPAT |-> EXEC_ENV.lin_4g &&
		EXEC_ENV.oper_size != opmode_pkg::SZ_64 && EXEC_ENV.addr_size != opmode_pkg::SZ_64 && !EXEC_ENV.vr86_act
		&& !EXEC_ENV.task_sw_ok) else $error("compatibility limits wrong");
endmodule

bind opmode_ctrl opmode_ctrl_properties props (.REF_CLK, .SYS_RST, .HSEL, .HTRANS, .HWRITE, .HREADY, .HREADYOUT,
	.SYS_MGMT_INTERRUPT_PIN_N, .PIC_SYS_MGMT_MSG, .EXEC_ENV);

// ---- dv/sysmgmt_source.sv ----
// far-side model: pin and controller-message sources of system-management requests
// assumes commands from the bench on rising edges of clk
`timescale 1ns/1ns
module sysmgmt_source (
	input  wire logic       clk,
	input  wire logic       pin_go,
	input  wire logic [3:0] hold,
	input  wire logic       msg_go,
	output logic            pin_n,
	output logic            msg
);
	logic [3:0] cnt_q = 4'h0;
	initial pin_n = 1'h1;
	initial msg = 1'h0;
	// pin held low for hold+1 cycles, then back to its pulled-up idle level
	always @(posedge clk) begin
		msg <= msg_go;
		if (pin_go) begin
			pin_n <= 1'h0;
			cnt_q <= hold;
		end else if (cnt_q != 4'h0)
			cnt_q <= cnt_q - 4'h1;
		else
			pin_n <= 1'h1;
	end
endmodule

// ---- dv/processor_operating_mode_control_tb_top.sv ----
// self-checking bench of the operating-mode controller
// assumes opmode_ctrl as sole bus slave, sysmgmt_source as request source
`timescale 1ns/1ns
module processor_operating_mode_control_tb_top;
	logic                  ref_clk = 1'h0;
	logic                  sys_rst = 1'h1;
	logic                  hsel = 1'h0;
	logic [31:0]           haddr = 32'h0;
	logic [1:0]            htrans = 2'h0;
	logic                  hwrite = 1'h0;
	logic [31:0]           hwdata = 32'h0;
	logic                  hready;
	logic [31:0]           hrdata;
	logic                  pin_n;
	logic                  msg;
	logic [2:0]            pulses = 3'h0;
	logic [3:0]            hold = 4'h1;
	opmode_pkg::exec_env_t env;
	logic [31:0]           rng = 32'h9F6;
	logic [31:0]           rd;
	logic [19:0]           e;
	logic [19:0]           seen;
	logic [2:0]            ctrl;
	logic [2:0]            seg;
	logic [3:0]            pfx;
	logic [2:0]            ctrl_tbl [5] = '{3'h0, 3'h1, 3'h5, 3'h3, 3'h7};
	int                    fails = 0;
	int                    checks_done = 0;

	always #4 ref_clk = ~ref_clk;
	assign seen = {env[31:24], env.gpr_count, env.gpr_width};
	opmode_ctrl dut (.REF_CLK(ref_clk), .SYS_RST(sys_rst), .HSEL(hsel), .HADDR(haddr), .HTRANS(htrans),
		.HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata), .HREADY(hready), .HREADYOUT(hready), .HRDATA(hrdata),
		.HRESP(), .SYS_MGMT_INTERRUPT_PIN_N(pin_n), .PIC_SYS_MGMT_MSG(msg), .INSN_RETIRE(pulses[2]),
		.EXEC_ENV(env));
	sysmgmt_source partner (.clk(ref_clk), .pin_go(pulses[0]), .hold(hold), .msg_go(pulses[1]), .pin_n(pin_n),
		.msg(msg));

	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [31:0] next_rand();
		rng = rng ^ (rng << 13);
		rng = rng ^ (rng >> 17);
		rng = rng ^ (rng << 5);
		return rng;
	endfunction
	// {mode, submode, addr, oper, gpr count, gpr width} for a register state
	function automatic logic [19:0] exp_env(logic [2:0] c, logic [2:0] s, logic [3:0] p);
		logic d;
		d = c[0] && s[1];
		if (c[1] && s[0])
			return {opmode_pkg::MODE_PROT, opmode_pkg::SUB_64, p[3] ? opmode_pkg::SZ_32 : opmode_pkg::SZ_64,
				p[0] && p[1] ? opmode_pkg::SZ_64 : p[2] ? opmode_pkg::SZ_16 : opmode_pkg::SZ_32,
				opmode_pkg::REGS_WIDE, opmode_pkg::GPR_W64};
		return {c[0] ? opmode_pkg::MODE_PROT : opmode_pkg::MODE_REAL,
			c[1] ? opmode_pkg::SUB_COMPAT : opmode_pkg::SUB_LEGACY, d ^ p[3] ? opmode_pkg::SZ_32 : opmode_pkg::SZ_16,
			d ^ p[2] ? opmode_pkg::SZ_32 : opmode_pkg::SZ_16, opmode_pkg::REGS_NARROW, opmode_pkg::GPR_W32};
	endfunction
	task automatic check(input logic [31:0] s, input logic [31:0] x);
		checks_done++;
		if (s !== x) begin
			fails++;
			$display("Error at %0t ns: seen %h expected %h", $time, s, x);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task automatic wait_rdy();
		int n;
		logic r;
		n = 0;
		r = 1'h0;
		while (!r) begin
			@(negedge ref_clk);
			r = hready === 1'h1;
			rd = hrdata;
			@(posedge ref_clk);
			n++;
			if (n > 20) begin
				fails++;
				complete_run();
			end
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		hsel <= 1'h1;
		htrans <= opmode_pkg::HTRANS_NONSEQ;
		haddr <= {24'h0, a};
		hwrite <= w;
		wait_rdy();
		hsel <= 1'h0;
		htrans <= 2'h0;
		hwdata <= d;
		wait_rdy();
	endtask
	task automatic look(input int n);
		repeat (n) @(posedge ref_clk);
		@(negedge ref_clk);
	endtask
	// one-cycle pulse: 0 pin request, 1 controller message, 2 instruction retire
	task automatic fire(input int k);
		@(posedge ref_clk);
		pulses <= 3'h1 << k;
		@(posedge ref_clk);
		pulses <= 3'h0;
	endtask

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (20) @(posedge ref_clk);
		sys_rst <= 1'h0;
		look(3);
		check({12'h0, seen}, {12'h0, exp_env(3'h0, 3'h0, 4'h0)});
		$display("test reset done");
		for (int i = 0; i < 16; i++) begin
			rd = next_rand();
			ctrl = ctrl_tbl[rd % 5];
			seg = rd[10:8];
			pfx = rd[7:4];
			if (i < 2) begin
				ctrl = 3'h3;
				seg = 3'h1;
				pfx = i ? 4'hF : 4'h3;
			end
			xfer(1'h1, opmode_pkg::OFS_CTRL, {29'h0, ctrl});
			xfer(1'h1, opmode_pkg::OFS_SEG, {29'h0, seg});
			xfer(1'h1, opmode_pkg::OFS_PREFIX, {28'h0, pfx});
			look(2);
			e = exp_env(ctrl, seg, pfx);
			check({12'h0, seen}, {12'h0, e});
			xfer(1'h0, opmode_pkg::OFS_STATUS, 32'h0);
			check({24'h0, rd[31:24]}, {24'h0, e[19:12]});
			fire(2);
			look(1);
			check({12'h0, seen}, {12'h0, exp_env(ctrl, seg, 4'h0)});
		end
		$display("test modes done");
		for (int k = 0; k < 2; k++) begin
			hold <= 4'(next_rand() % 8) + 4'h1;
			fire(k);
			look(8);
			e = exp_env(3'h0, 3'h0, 4'h0);
			e[19:18] = opmode_pkg::MODE_SYSMGMT;
			check({11'h0, seen, env.smram_sel}, {11'h0, e, 1'h1});
			xfer(1'h0, opmode_pkg::OFS_SAVED, 32'h0);
			check(rd, {24'h0, ctrl[0] ? opmode_pkg::MODE_PROT : opmode_pkg::MODE_REAL, ctrl, seg});
			xfer(1'h1, opmode_pkg::OFS_SMRET, 32'h1);
			look(2);
			check({12'h0, seen}, {12'h0, exp_env(ctrl, seg, 4'h0)});
		end
		// a pin request while inside is kept and taken right after return
		fire(1);
		look(4);
		fire(0);
		look(8);
		xfer(1'h1, opmode_pkg::OFS_SMRET, 32'h1);
		look(2);
		check({11'h0, seen, env.smram_sel}, {11'h0, e, 1'h1});
		xfer(1'h1, opmode_pkg::OFS_SMRET, 32'h1);
		look(2);
		check({12'h0, seen}, {12'h0, exp_env(ctrl, seg, 4'h0)});
		$display("test sysmgmt done");
		xfer(1'h0, 8'h18, 32'h0);
		check(rd, 32'h0);
		xfer(1'h1, opmode_pkg::OFS_STATUS, 32'hFFFFFFFF);
		xfer(1'h1, opmode_pkg::OFS_SMRET, 32'h1);
		look(2);
		check({12'h0, seen}, {12'h0, exp_env(ctrl, seg, 4'h0)});
		$display("test refused done");
		@(posedge ref_clk);
		sys_rst <= 1'h1;
		repeat (2) @(posedge ref_clk);
		sys_rst <= 1'h0;
		look(3);
		check({12'h0, seen}, {12'h0, exp_env(3'h0, 3'h0, 4'h0)});
		$display("test second reset done");
		complete_run();
	end
endmodule
